// ---- include/gdps_pkg.sv ----
/*
  Constants and carrier types for the primary-side status register pair.
  Assumes one 10 MHz clock and a synchronous active-low reset.
*/
package gdps_pkg;

  // ------------------------------------------------------------
  // Register offsets (word index on the serial link)
  // ------------------------------------------------------------
  localparam logic [3:0]  GDPS_ADDR_STATUS        = 4'h1;
  localparam logic [3:0]  GDPS_ADDR_STATUS_SECOND = 4'h2;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] GDPS_STATUS_RESET        = 16'h087D;
  localparam logic [15:0] GDPS_STATUS_SECOND_RESET = 16'h0010;
  localparam logic [1:0]  GDPS_TON_RESET           = 2'h0;
  localparam logic [3:0]  GDPS_TOFF_RESET          = 4'hF;
  localparam logic        GDPS_READY_RESET         = 1'b1;
  localparam logic        GDPS_FAULT_A_RESET       = 1'b0;
  localparam logic        GDPS_FAULT_B_RESET       = 1'b1;

  // ------------------------------------------------------------
  // Field positions, both words
  // ------------------------------------------------------------
  localparam int GDPS_ERR_BIT     = 11;
  localparam int GDPS_TON_LSB     = 8;
  localparam int GDPS_RUN_BIT     = 7;
  localparam int GDPS_READY_BIT   = 6;
  localparam int GDPS_TOFF_LSB    = 2;
  localparam int GDPS_FLOATC_BIT  = 11;
  localparam int GDPS_SHOOT_BIT   = 10;
  localparam int GDPS_HEAT_BIT    = 9;
  localparam int GDPS_FLOATS_BIT  = 8;
  localparam int GDPS_MODE_LSB    = 5;
  localparam int GDPS_FAULTB_BIT  = 4;
  localparam int GDPS_FAULTA_BIT  = 3;
  localparam int GDPS_ENABLE_INPUT_VALID_BIT   = 2;
  localparam int GDPS_REJECT_BIT  = 1;
  localparam int GDPS_PARITY_BIT  = 0;

  // ------------------------------------------------------------
  // Modes and timing
  // ------------------------------------------------------------
  localparam logic [2:0]  GDPS_RUN_STATE_MODE   = 3'h4;
  localparam int          GDPS_ENABLE_INPUT_VALID_STABLE_CYC = 4;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic       float_control;
    logic       shoot_block;
    logic       overheat;
    logic       floating;
    logic [2:0] mode;
    logic       ready;
  } gdps_sec_t;

  typedef struct packed {
    logic       on_valid;
    logic [1:0] on_level;
    logic       off_valid;
    logic [3:0] off_level;
  } gdps_plat_t;

endpackage : gdps_pkg

// ---- core/gdps_status_regs.sv ----
/*
  Primary-side read-only status registers of an isolated gate driver.
  Assumes the serial front end delivers decoded read/write strokes,
  accepted plateau requests, the message-reject flag and the error word
  on this clock; secondary mirrors and the enable pin arrive asynchronously.
*/
// What this block does
// R1 - Error summary bit is OR of errors
// R2 - Reserved positions always read zero
// R3 - Run flag set only in mode four
// R4 - Bit 6 shows secondary die ready
// R5 - Bits 9:8 hold last turn-on request
// R6 - Bits 5:2 hold last turn-off request
// R7 - Bit 1 flags last frame rejected
// R8 - Bit 0 is odd parity of word
// R9 - Bit 11 mirrors secondary float control
// R10 - Bit 10 shows shoot-through inhibition active
// R11 - Bit 9 mirrors secondary overheat status
// R12 - Bit 8 mirrors secondary floating status
// R13 - Bits 7:5 mirror secondary mode code
// R14 - Sticky fault bits set on pin low
// R15 - Bit 2 shows enable input valid
// R16 - Besides pin low, only reset changes sticky bits; it clears bit 3 and sets bit 4
// R17 - Host writes to status words ignored
module gdps_status_regs #(
  parameter int ENABLE_INPUT_VALID_STABLE_CYC = gdps_pkg::GDPS_ENABLE_INPUT_VALID_STABLE_CYC
) (
  // Clock and reset
  input  wire logic              clock_in,
  input  wire logic              rstn_in,
  // Register access from serial front end
  input  wire logic              rd_req_in,
  input  wire logic              wr_req_in,
  input  wire logic [3:0]        addr_in,
  output logic      [15:0]       rd_data_out,
  output logic                   rd_valid_out,
  output logic                   rd_hit_out,
  // Front-end state
  input  wire logic [15:0]       error_word_in,
  input  wire logic              last_frame_rejected_in,
  input  wire gdps_pkg::gdps_plat_t plateau_req_in,
  // Secondary mirrors and pins
  input  wire gdps_pkg::gdps_sec_t  secondary_in,
  input  wire logic              enable_pin_in,
  input  wire logic              fault_out_a_req_in,
  input  wire logic              fault_out_b_req_in,
  output logic                   fault_out_a_pin_out,
  output logic                   fault_out_a_pin_oe_out,
  output logic                   fault_out_b_pin_out,
  output logic                   fault_out_b_pin_oe_out,
  // Live status words
  output logic      [15:0]       status_word_out,
  output logic      [15:0]       status_second_word_out
);
  import gdps_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] add_odd_parity(input logic [15:0] word);
    logic [15:0] w;
    w = word;
    w[GDPS_PARITY_BIT] = ~(^word[15:1]); // R8
    return w;
  endfunction : add_odd_parity

  localparam gdps_sec_t SEC_RESET = '{
    float_control: 1'b0,
    shoot_block:   1'b0,
    overheat:      1'b0,
    floating:      1'b0,
    mode:          3'h0,
    ready:         GDPS_READY_RESET
  };

  localparam int CNT_W = $clog2(ENABLE_INPUT_VALID_STABLE_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(ENABLE_INPUT_VALID_STABLE_CYC);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  gdps_sec_t        sec_meta_reg;
  gdps_sec_t        sec_sync_reg;
  logic             en_meta_reg;
  logic             en_sync_reg;
  logic             en_prev_reg;
  logic [CNT_W-1:0] en_cnt_reg;
  logic             en_valid_reg;
  logic [1:0]       ton_reg;
  logic [3:0]       toff_reg;
  logic             reject_reg;
  logic             err_reg;
  logic             fault_a_drive_reg;
  logic             fault_b_drive_reg;
  logic             fault_a_seen_reg;
  logic             fault_b_seen_reg;
  logic [15:0]      status_next;
  logic [15:0]      status_second_next;
  logic [15:0]      rd_data_next;
  logic             rd_hit_next;

  // ------------------------------------------------------------
  // Synchronisers for secondary mirrors and enable pin
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      sec_meta_reg <= SEC_RESET;
      sec_sync_reg <= SEC_RESET;
    end else begin
      sec_meta_reg <= secondary_in;
      sec_sync_reg <= sec_meta_reg;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
    end else begin
      en_meta_reg <= enable_pin_in;
      en_sync_reg <= en_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // Enable validity: level must stand still long enough
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      en_prev_reg  <= 1'b0;
      en_cnt_reg   <= '0;
      en_valid_reg <= 1'b0;
    end else begin
      en_prev_reg <= en_sync_reg;
      if (en_sync_reg != en_prev_reg) begin
        en_cnt_reg   <= '0;
        en_valid_reg <= 1'b0; // R15
      end else if (en_cnt_reg != CNT_MAX) begin
        en_cnt_reg   <= en_cnt_reg + CNT_W'(1);
        en_valid_reg <= 1'b0;
      end else begin
        en_valid_reg <= 1'b1; // R15
      end
    end
  end

  // ------------------------------------------------------------
  // Latest plateau requests accepted over the serial link
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      ton_reg <= GDPS_TON_RESET;
    end else if (plateau_req_in.on_valid) begin
      ton_reg <= plateau_req_in.on_level; // R5
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      toff_reg <= GDPS_TOFF_RESET;
    end else if (plateau_req_in.off_valid) begin
      toff_reg <= plateau_req_in.off_level; // R6
    end
  end

  // ------------------------------------------------------------
  // Message reject and error summary
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      reject_reg <= 1'b0;
    end else begin
      reject_reg <= last_frame_rejected_in; // R7
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      err_reg <= 1'b1;
    end else begin
      err_reg <= |error_word_in; // R1
    end
  end

  // ------------------------------------------------------------
  // Fault notification pins (open drain, low when requested)
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      fault_a_drive_reg <= 1'b0;
      fault_b_drive_reg <= 1'b0;
    end else begin
      fault_a_drive_reg <= fault_out_a_req_in;
      fault_b_drive_reg <= fault_out_b_req_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      fault_out_a_pin_out    <= 1'b0;
      fault_out_b_pin_out    <= 1'b0;
      fault_out_a_pin_oe_out <= 1'b0;
      fault_out_b_pin_oe_out <= 1'b0;
    end else begin
      fault_out_a_pin_out    <= 1'b0;
      fault_out_b_pin_out    <= 1'b0;
      fault_out_a_pin_oe_out <= fault_a_drive_reg;
      fault_out_b_pin_oe_out <= fault_b_drive_reg;
    end
  end

  // ------------------------------------------------------------
  // Sticky fault request bits; set while a fault pin is driven low, otherwise only reset changes them, clearing A and setting B
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      fault_a_seen_reg <= GDPS_FAULT_A_RESET; // R16
      fault_b_seen_reg <= GDPS_FAULT_B_RESET; // R16
    end else begin
      fault_a_seen_reg <= fault_a_seen_reg | fault_out_a_pin_oe_out; // R14
      fault_b_seen_reg <= fault_b_seen_reg | fault_out_b_pin_oe_out; // R14
    end
  end

  // ------------------------------------------------------------
  // Status word assembly
  // ------------------------------------------------------------
  always_comb begin
    status_next = 16'h0000; // R2
    status_next[GDPS_ERR_BIT] = err_reg;
    status_next[GDPS_TON_LSB +: 2] = ton_reg;
    status_next[GDPS_RUN_BIT] = (sec_sync_reg.mode == GDPS_RUN_STATE_MODE); // R3
    status_next[GDPS_READY_BIT] = sec_sync_reg.ready; // R4
    status_next[GDPS_TOFF_LSB +: 4] = toff_reg;
    status_next[GDPS_REJECT_BIT] = reject_reg;
    status_next = add_odd_parity(status_next); // R8
  end

  always_comb begin
    status_second_next = 16'h0000; // R2
    status_second_next[GDPS_FLOATC_BIT] = sec_sync_reg.float_control; // R9
    status_second_next[GDPS_SHOOT_BIT] = sec_sync_reg.shoot_block; // R10
    status_second_next[GDPS_HEAT_BIT] = sec_sync_reg.overheat; // R11
    status_second_next[GDPS_FLOATS_BIT] = sec_sync_reg.floating; // R12
    status_second_next[GDPS_MODE_LSB +: 3] = sec_sync_reg.mode; // R13
    status_second_next[GDPS_FAULTB_BIT] = fault_b_seen_reg;
    status_second_next[GDPS_FAULTA_BIT] = fault_a_seen_reg;
    status_second_next[GDPS_ENABLE_INPUT_VALID_BIT] = en_valid_reg;
    status_second_next[GDPS_REJECT_BIT] = reject_reg; // R7
    status_second_next = add_odd_parity(status_second_next); // R8
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      status_word_out        <= GDPS_STATUS_RESET;
      status_second_word_out <= GDPS_STATUS_SECOND_RESET;
    end else begin
      status_word_out        <= status_next;
      status_second_word_out <= status_second_next;
    end
  end

  // ------------------------------------------------------------
  // Read port; writes change nothing
  // ------------------------------------------------------------
  always_comb begin
    rd_data_next = 16'h0000;
    rd_hit_next  = 1'b0;
    case (addr_in)
      GDPS_ADDR_STATUS: begin
        rd_data_next = status_next;
        rd_hit_next  = 1'b1;
      end
      GDPS_ADDR_STATUS_SECOND: begin
        rd_data_next = status_second_next;
        rd_hit_next  = 1'b1;
      end
      default: begin
        rd_data_next = 16'h0000;
        rd_hit_next  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      rd_data_out  <= 16'h0000;
      rd_valid_out <= 1'b0;
      rd_hit_out   <= 1'b0;
    end else if (rd_req_in && !wr_req_in) begin
      rd_data_out  <= rd_data_next;
      rd_valid_out <= 1'b1;
      rd_hit_out   <= rd_hit_next;
    end else begin
      rd_valid_out <= 1'b0; // R17
      rd_hit_out   <= 1'b0;
    end
  end

endmodule : gdps_status_regs

// ---- testbench/gdps_status_checker.sv ----
/*
  Assertions on the status register pair, seen from its ports.
  Assumes one clock and a synchronous active-low reset.
*/
module gdps_status_checker import gdps_pkg::*; (
  // Clock, reset and register port
  input wire logic        clock_in,
  input wire logic        rstn_in,
  input wire logic        rd_req_in,
  input wire logic        wr_req_in,
  input wire logic [3:0]  addr_in,
  input wire logic        rd_valid_out,
  input wire logic        rd_hit_out,
  // Sources and live words
  input wire logic [15:0] error_word_in,
  input wire logic        fault_out_a_req_in,
  input wire logic        fault_out_a_pin_oe_out,
  input wire logic        fault_out_b_req_in,
  input wire logic        fault_out_a_pin_out,
  input wire logic        fault_out_b_pin_out,
  input wire logic        fault_out_b_pin_oe_out,
  input wire logic [15:0] status_word_out,
  input wire logic [15:0] status_second_word_out
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic       err_any = |error_word_in;
  wire logic       addr_ok = (addr_in == 4'h1) || (addr_in == 4'h2);
  wire logic [1:0] stk     = status_second_word_out[4:3];

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  property p_rsv; {status_word_out[15:10], status_second_word_out[15:12]} ==? 10'b0000_?0_0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_par; ^status_word_out && ^status_second_word_out; endproperty
  a_par: assert property (p_par) else $error("bad parity");
  property p_err; $past(rstn_in) && $past(rstn_in, 2) |-> status_word_out[11] == $past(err_any, 2);
  endproperty
  a_err: assert property (p_err) else $error("bad error summary");
  property p_run; status_word_out[7] == (status_second_word_out[7:5] == 3'h4); endproperty
  a_run: assert property (p_run) else $error("bad run flag");
  property p_rd; rd_req_in && !wr_req_in |=> rd_valid_out && rd_hit_out == $past(addr_ok);
  endproperty
  a_rd: assert property (p_rd) else $error("bad read answer");
  property p_wr; wr_req_in |=> !rd_valid_out; endproperty
  a_wr: assert property (p_wr) else $error("write answered");
  property p_stick; (stk | $past(stk)) == stk; endproperty
  a_stick: assert property (p_stick) else $error("sticky bit cleared");
  property p_oe; fault_out_a_req_in |-> ##2 fault_out_a_pin_oe_out ##2 stk[0]; endproperty
  a_oe: assert property (p_oe) else $error("fault pin or sticky late");
  property p_oeb; fault_out_b_req_in |-> ##2 fault_out_b_pin_oe_out ##2 stk[1]; endproperty
  a_oeb: assert property (p_oeb) else $error("fault pin B or sticky late");
  property p_rel; !fault_out_a_req_in |-> ##2 !fault_out_a_pin_oe_out; endproperty
  a_rel: assert property (p_rel) else $error("fault pin A held without request");
  property p_low; !fault_out_a_pin_out && !fault_out_b_pin_out; endproperty
  a_low: assert property (p_low) else $error("fault pin driven high");

  cover property (rd_req_in && !wr_req_in && addr_in == 4'h2);
  cover property (fault_out_a_pin_oe_out);
  cover property (status_word_out[7]);
endmodule : gdps_status_checker

bind gdps_status_regs gdps_status_checker u_chk (
  .clock_in(clock_in), .rstn_in(rstn_in), .rd_req_in(rd_req_in), .wr_req_in(wr_req_in),
  .addr_in(addr_in), .rd_valid_out(rd_valid_out), .rd_hit_out(rd_hit_out),
  .error_word_in(error_word_in), .fault_out_a_req_in(fault_out_a_req_in),
  .fault_out_a_pin_oe_out(fault_out_a_pin_oe_out), .fault_out_b_req_in(fault_out_b_req_in),
  .fault_out_a_pin_out(fault_out_a_pin_out), .fault_out_b_pin_out(fault_out_b_pin_out),
  .fault_out_b_pin_oe_out(fault_out_b_pin_oe_out), .status_word_out(status_word_out),
  .status_second_word_out(status_second_word_out));

// ---- testbench/gdps_host_model.sv ----
/*
  Host model issuing read and write strokes to the status block.
  Assumes strokes are sampled on the rising clock edge.
*/
module gdps_host_model (
  // Clock
  input  wire logic  clock_in,
  // Register strokes
  output logic       rd_req_out,
  output logic       wr_req_out,
  output logic [3:0] addr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {rd_req_out, wr_req_out, addr_out} = 6'h00;

  task automatic acc(input logic rd, input logic wr, input logic [3:0] a);
    @(negedge clock_in);
    rd_req_out = rd;
    wr_req_out = wr;
    addr_out = a;
  endtask : acc
endmodule : gdps_host_model

// ---- testbench/gdps_status_regs_tb_top.sv ----
/*
  Self-checking bench for the status register pair.
  Assumes the host model and the checker are compiled first.
*/
module gdps_status_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import gdps_pkg::*;
  typedef struct packed {logic [15:0] d; logic h;} gdps_exp_t;
  logic        clock_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        rd_req, wr_req, rd_valid, rd_hit, rej, en, fa_req, fb_req;
  logic        fa_pin, fa_oe, fb_pin, fb_oe;
  logic        pen = 1'b0;
  logic        fa = 1'b0;
  logic        fb = 1'b1;
  logic [1:0]  ton = 2'h0;
  logic [3:0]  toff = 4'hF;
  logic [3:0]  addr, a;
  logic [15:0] err, rd_data, w_st, w_nd, x;
  logic [31:0] r, seed = 32'h5374B455;
  gdps_plat_t  plat;
  gdps_sec_t   sec;
  gdps_exp_t   e;
  gdps_exp_t   q[$];
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;

  gdps_host_model host (.clock_in(clock_in), .rd_req_out(rd_req), .wr_req_out(wr_req),
    .addr_out(addr));
  gdps_status_regs #(.ENABLE_INPUT_VALID_STABLE_CYC(1)) dut (
    .clock_in(clock_in), .rstn_in(rstn_in), .rd_req_in(rd_req), .wr_req_in(wr_req),
    .addr_in(addr), .rd_data_out(rd_data), .rd_valid_out(rd_valid), .rd_hit_out(rd_hit),
    .error_word_in(err), .last_frame_rejected_in(rej), .plateau_req_in(plat),
    .secondary_in(sec), .enable_pin_in(en), .fault_out_a_req_in(fa_req),
    .fault_out_b_req_in(fb_req), .fault_out_a_pin_out(fa_pin), .fault_out_a_pin_oe_out(fa_oe),
    .fault_out_b_pin_out(fb_pin), .fault_out_b_pin_oe_out(fb_oe), .status_word_out(w_st),
    .status_second_word_out(w_nd));

  initial forever #50 clock_in = ~clock_in;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [15:0] odd_par(input logic [15:0] w);
    return {w[15:1], ~^w[15:1]};
  endfunction : odd_par

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // ------------------------------------------------------------
  // Read monitor
  // ------------------------------------------------------------
  always @(negedge clock_in) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      final_report();
    end
    if (rd_valid && q.size() > 0) begin
      e = q.pop_front();
      check(rd_data, e.d);
      check(16'(rd_hit), 16'(e.h));
    end else if (rd_valid) begin
      check(16'h0001, 16'h0000);
    end
  end

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial begin
    {err, rej, en, fa_req, fb_req, plat, sec} = '0;
    sec.ready = 1'b1;
    repeat (10) @(negedge clock_in);
    check(w_st, 16'h087D);
    check(w_nd, 16'h0010);
    rstn_in = 1'b1;
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      err = r[3] ? 16'h0000 : 16'h0001 << r[7:4];
      sec = r[15:8];
      {rej, en} = r[17:16];
      plat = {r[24], r[19:18], r[25], r[23:20]};
      if (r[24]) ton = r[19:18];
      if (r[25]) toff = r[23:20];
      fa_req = &r[27:26];
      fb_req = &r[29:28];
      fa |= fa_req;
      fb |= fb_req;
      @(negedge clock_in);
      {plat, fa_req, fb_req} = '0;
      @(negedge clock_in);
      check(16'({fa_oe, fb_oe, fa_pin, fb_pin}), 16'({&r[27:26], &r[29:28], 2'b00}));
      repeat (2) @(negedge clock_in);
      check(16'(w_nd[2]), 16'(en == pen));
      pen = en;
      if (i == 12) begin
        rstn_in = 1'b0;
        repeat (2) @(negedge clock_in);
        {rstn_in, fa, fb, ton, toff} = {3'h5, 2'h0, 4'hF};
      end
      repeat (10) @(negedge clock_in);
      a = (r[31:28] inside {4'h1, 4'h2}) ? 4'h0 : r[31:28];
      x = odd_par({4'h0, |err, 1'b0, ton, sec.mode == 3'h4, sec.ready, toff, rej, 1'b0});
      q.push_back({x, 1'b1});
      check(w_st, x);
      x = odd_par({4'h0, sec[7:4], sec.mode, fb, fa, 1'b1, rej, 1'b0});
      q.push_back({x, 1'b1});
      check(w_nd, x);
      q.push_back({16'h0000, 1'b0});
      host.acc(1'b1, 1'b0, 4'h1);
      host.acc(1'b1, 1'b0, 4'h2);
      host.acc(1'b1, 1'b0, a);
      host.acc(1'b1, 1'b1, 4'h1);
      host.acc(1'b0, 1'b1, 4'h2);
      host.acc(1'b0, 1'b0, ~a);
    end
    repeat (4) @(negedge clock_in);
    check(16'(q.size()), 16'h0000);
    final_report();
  end
endmodule : gdps_status_regs_tb_top
